// ==== logic/art_timer.sv ====
// 8-bit auto-reload PWM timer with captures, reached over APB
`timescale 1ns/1ps
module art_timer #(
	parameter int NUM_PWM = art_pkg::NUM_PWM,
	parameter int NUM_CAP = art_pkg::NUM_CAP
) (
	input  wire logic               ref_clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [11:0]        paddr_in,
	input  wire logic [31:0]        pwdata_in,
	input  wire logic [3:0]         pstrb_in,
	output logic      [31:0]        prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	input  wire logic               halted_in,
	input  wire logic               ext_clock_in,
	input  wire logic [NUM_CAP-1:0] capture_input_n_in,
	output logic      [NUM_PWM-1:0] pulse_output_n_out,
	output logic      [NUM_PWM-1:0] pulse_output_n_oe_out,
	output logic                    overflow_irq_out,
	output logic      [NUM_CAP-1:0] capture_irq_out,
	output logic                    wake_out
);
	art_pkg::art_ctrl_s    ctrl;
	art_pkg::art_cap_cfg_s cap_cfg;
	logic [7:0]             count;
	logic [7:0]             reload;
	logic [NUM_PWM-1:0]     out_en;
	logic [NUM_PWM-1:0]     polarity;
	logic [7:0]             duty      [NUM_PWM];
	logic [7:0]             compare   [NUM_PWM];
	logic [7:0]             cap_val   [NUM_CAP];
	logic [NUM_CAP-1:0]     cap_flag;
	logic                   ovf_flag;
	logic [art_pkg::PRESC_BITS-1:0] presc;
	logic [1:0]             ext_sync;
	logic                   ext_prev;
	logic [1:0]             cap_sync  [NUM_CAP];
	logic [NUM_CAP-1:0]     cap_prev;

	// APB access: one wait-free cycle, taken in the access phase
	logic       acc;
	logic       wr;
	logic       rd;
	logic [9:0] idx;
	logic [7:0] wbyte;
	assign acc   = psel_in && penable_in;
	assign wr    = acc && pwrite_in && pstrb_in[0];
	assign rd    = acc && !pwrite_in;
	assign idx   = paddr_in[11:2];
	assign wbyte = pwdata_in[7:0];

	function automatic logic hit(input logic [9:0] a, input logic [7:0] r);
		return a == {2'b00, r};
	endfunction

	function automatic logic known(input logic [9:0] a);
		return a >= {2'b00, art_pkg::IDX_DUTY3} && a <= {2'b00, art_pkg::IDX_CAP2};
	endfunction

	// sync external clock and capture pins
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_sync <= 2'b00;
		end else begin
			ext_sync <= {ext_sync[0], ext_clock_in};
		end
	end

	// Edge history reads only the second stage, never the metastable first one
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= ext_sync[1];
		end
	end

	logic [NUM_CAP-1:0] cap_edge;
	genvar g;
	generate
		for (g = 0; g < NUM_CAP; g++) begin : g_cap
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cap_sync[g] <= 2'b00;
				end else begin
					cap_sync[g] <= {cap_sync[g][0], capture_input_n_in[g]};
				end
			end

			// Previous level for edge detection
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cap_prev[g] <= 1'b0;
				end else begin
					cap_prev[g] <= cap_sync[g][1];
				end
			end
			assign cap_edge[g] = cap_cfg.sens[g] ? (cap_sync[g][1] && !cap_prev[g])
				: (!cap_sync[g][1] && cap_prev[g]);
		end
	endgenerate

	// clock source: CPU clock ticks every cycle, external on rising edge
	logic in_tick;
	assign in_tick = ctrl.clock_source_select ? (ext_sync[1] && !ext_prev) : 1'b1;

	// tap of prescaler: all lower bits set at next input tick
	logic [art_pkg::PRESC_BITS-1:0] tap_mask;
	logic                           cnt_tick;
	assign tap_mask = art_pkg::PRESC_BITS'((8'h01 << ctrl.counter_divider) - 8'h01);
	assign cnt_tick = ctrl.counter_run && in_tick && ((presc & tap_mask) == tap_mask);

	logic force_rl;
	logic car_wr;
	logic ovf_evt;
	assign force_rl = wr && hit(idx, art_pkg::IDX_TCS) && wbyte[art_pkg::TCS_FRELOAD];
	assign car_wr   = wr && hit(idx, art_pkg::IDX_CAR);
	// overflow on the tick that wraps FFh
	assign ovf_evt  = cnt_tick && count == art_pkg::COUNT_TOP && !car_wr && !force_rl;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			presc <= '0;
		end else if (force_rl || car_wr) begin
			// force reload or counter write clears prescaler
			presc <= '0;
		end else if (ctrl.counter_run && in_tick) begin
			presc <= presc + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= art_pkg::RESET_BYTE;
		end else if (car_wr) begin
			count <= wbyte;
		end else if (force_rl) begin
			count <= reload;
		end else if (ovf_evt) begin
			count <= reload;
		end else if (cnt_tick) begin
			count <= count + 8'h01;
		end
	end

	// Control registers, one process per register
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= '0;
		end else if (wr && hit(idx, art_pkg::IDX_TCS)) begin
			ctrl.clock_source_select <= wbyte[art_pkg::TCS_CLK_SRC];
			ctrl.counter_divider     <= wbyte[art_pkg::TCS_DIV_HI:art_pkg::TCS_DIV_LO];
			ctrl.counter_run         <= wbyte[art_pkg::TCS_RUN];
			ctrl.overflow_irq_enable <= wbyte[art_pkg::TCS_OVF_IE];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reload <= art_pkg::RESET_BYTE;
		end else if (wr && hit(idx, art_pkg::IDX_ARR)) begin
			reload <= wbyte;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_en   <= '0;
			polarity <= '0;
		end else if (wr && hit(idx, art_pkg::IDX_PWM_OUTPUT_CONTROL)) begin
			out_en   <= wbyte[art_pkg::PWM_OE_LO +: NUM_PWM];
			polarity <= wbyte[NUM_PWM-1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cap_cfg <= '0;
		end else if (wr && hit(idx, art_pkg::IDX_CCS)) begin
			cap_cfg.sens               <= wbyte[art_pkg::CCS_SENS_LO +: NUM_CAP];
			cap_cfg.capture_irq_enable <= wbyte[art_pkg::CCS_IE_LO +: NUM_CAP];
		end
	end

	// overflow flag, set wins over the read clear
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ovf_flag <= 1'b0;
		end else if (ovf_evt) begin
			ovf_flag <= 1'b1;
		end else if (rd && hit(idx, art_pkg::IDX_TCS)) begin
			ovf_flag <= 1'b0;
		end
	end

	generate
		for (g = 0; g < NUM_PWM; g++) begin : g_pwm
			logic [7:0] duty_idx;
			assign duty_idx = art_pkg::IDX_DUTY0 - 8'(g);
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					duty[g] <= art_pkg::RESET_BYTE;
				end else if (wr && hit(idx, duty_idx)) begin
					duty[g] <= wbyte;
				end
			end
			// shadow reload at overflow keeps duty changes glitch free
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					compare[g] <= art_pkg::RESET_BYTE;
				end else if (ovf_evt) begin
					compare[g] <= duty[g];
				end
			end
			// level from compare, polarity applied combinationally into the flop
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					pulse_output_n_out[g] <= 1'b0;
				end else begin
					pulse_output_n_out[g] <= (count <= compare[g]) ^ polarity[g];
				end
			end
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					pulse_output_n_oe_out[g] <= 1'b0;
				end else begin
					pulse_output_n_oe_out[g] <= out_en[g];
				end
			end
		end

		for (g = 0; g < NUM_CAP; g++) begin : g_capreg
			logic [7:0] cap_idx;
			assign cap_idx = art_pkg::IDX_CAP1 + 8'(g);
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cap_val[g] <= art_pkg::RESET_BYTE;
				end else if (cap_edge[g] && !cap_flag[g]) begin
					cap_val[g] <= count;
				end
			end
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cap_flag[g] <= 1'b0;
				end else if (cap_edge[g] && !cap_flag[g]) begin
					cap_flag[g] <= 1'b1;
				end else if (rd && hit(idx, cap_idx)) begin
					cap_flag[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			overflow_irq_out <= 1'b0;
		end else begin
			overflow_irq_out <= ovf_flag && ctrl.overflow_irq_enable;
		end
	end

	// capture requests stay pending while the flag is set
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			capture_irq_out <= '0;
		end else begin
			capture_irq_out <= cap_flag & cap_cfg.capture_irq_enable;
		end
	end

	// wake on any enabled edge, even one blocked by a set flag
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_out <= 1'b0;
		end else begin
			wake_out <= halted_in && |(cap_edge & cap_cfg.capture_irq_enable);
		end
	end

	// Read mux
	logic [7:0] rbyte;
	always_comb begin
		rbyte = art_pkg::RESET_BYTE;
		if (hit(idx, art_pkg::IDX_TCS)) begin
			rbyte = {ctrl.clock_source_select, ctrl.counter_divider, ctrl.counter_run,
				1'b0, ctrl.overflow_irq_enable, ovf_flag};
		end else if (hit(idx, art_pkg::IDX_CAR)) begin
			rbyte = count;
		end else if (hit(idx, art_pkg::IDX_ARR)) begin
			rbyte = reload;
		end else if (hit(idx, art_pkg::IDX_PWM_OUTPUT_CONTROL)) begin
			rbyte = {out_en, polarity};
		end else if (hit(idx, art_pkg::IDX_CCS)) begin
			rbyte = {2'b00, cap_cfg.sens, cap_cfg.capture_irq_enable, cap_flag};
		end else if (hit(idx, art_pkg::IDX_CAP1)) begin
			rbyte = cap_val[0];
		end else if (hit(idx, art_pkg::IDX_CAP2)) begin
			rbyte = cap_val[1];
		end else if (hit(idx, art_pkg::IDX_DUTY0)) begin
			rbyte = duty[0];
		end else if (hit(idx, art_pkg::IDX_DUTY1)) begin
			rbyte = duty[1];
		end else if (hit(idx, art_pkg::IDX_DUTY2)) begin
			rbyte = duty[2];
		end else if (hit(idx, art_pkg::IDX_DUTY3)) begin
			rbyte = duty[3];
		end
	end

	// Answer registered; pready is high in the first access cycle
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out <= 1'b0;
		end else begin
			pready_out <= psel_in && !penable_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pslverr_out <= 1'b0;
		end else begin
			pslverr_out <= psel_in && !penable_in && !known(paddr_in[11:2]);
		end
	end

	// Read data sampled from the setup address so it stands in the access cycle
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out <= '0;
		end else begin
			prdata_out <= {24'h000000, rbyte};
		end
	end
endmodule

// ==== include/art_pkg.sv ====
// Package for the auto-reload PWM timer: register map, fields and carriers
package art_pkg;
	localparam int        NUM_PWM     = 4;
	localparam int        NUM_CAP     = 2;
	localparam int        PRESC_BITS  = 7;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_DUTY3   = 8'h73;
	localparam logic [7:0] IDX_DUTY2   = 8'h74;
	localparam logic [7:0] IDX_DUTY1   = 8'h75;
	localparam logic [7:0] IDX_DUTY0   = 8'h76;
	localparam logic [7:0] IDX_PWM_OUTPUT_CONTROL   = 8'h77;
	localparam logic [7:0] IDX_TCS     = 8'h78;
	localparam logic [7:0] IDX_CAR     = 8'h79;
	localparam logic [7:0] IDX_ARR     = 8'h7a;
	localparam logic [7:0] IDX_CCS     = 8'h7b;
	localparam logic [7:0] IDX_CAP1    = 8'h7c;
	localparam logic [7:0] IDX_CAP2    = 8'h7d;
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [7:0] COUNT_TOP   = 8'hff;
	// Field positions in timer_control_status
	localparam int         TCS_CLK_SRC = 7;
	localparam int         TCS_DIV_HI  = 6;
	localparam int         TCS_DIV_LO  = 4;
	localparam int         TCS_RUN     = 3;
	localparam int         TCS_FRELOAD = 2;
	localparam int         TCS_OVF_IE  = 1;
	localparam int         TCS_OVF     = 0;
	// Field positions in capture_control_status, then the PWM output enable field
	localparam int         CCS_SENS_LO = 4;
	localparam int         CCS_IE_LO   = 2;
	localparam int         CCS_FLAG_LO = 0;
	localparam int         PWM_OE_LO   = 4;

	typedef struct packed {
		logic       clock_source_select;
		logic [2:0] counter_divider;
		logic       counter_run;
		logic       overflow_irq_enable;
	} art_ctrl_s;

	typedef struct packed {
		logic [NUM_CAP-1:0] sens;
		logic [NUM_CAP-1:0] capture_irq_enable;
	} art_cap_cfg_s;
endpackage

// ==== bench/art_timer_sva.sv ====
// Checker for the timer's bus answers, flag clearing and pin rules
`timescale 1ns/1ps
module art_timer_sva #(
	parameter int NUM_PWM = 4,
	parameter int NUM_CAP = 2
) (
	input wire logic               ref_clk_in,
	input wire logic               rst_n_in,
	input wire logic               psel_in,
	input wire logic               penable_in,
	input wire logic               pwrite_in,
	input wire logic [11:0]        paddr_in,
	input wire logic [31:0]        prdata_out,
	input wire logic               pready_out,
	input wire logic               pslverr_out,
	input wire logic               halted_in,
	input wire logic [NUM_PWM-1:0] pulse_output_n_oe_out,
	input wire logic               overflow_irq_out,
	input wire logic [NUM_CAP-1:0] capture_irq_out,
	input wire logic               wake_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic acc, rd, pw, tcs, c1;
	assign acc = psel_in && penable_in && pready_out;
	assign rd = acc && !pwrite_in;
	assign pw = acc && pwrite_in && paddr_in == 12'h1dc;
	assign tcs = acc && paddr_in == 12'h1e0;
	assign c1 = rd && paddr_in == 12'h1f0 || acc && pwrite_in && paddr_in == 12'h1ec;
	sequence setup_s;
		psel_in && !penable_in;
	endsequence
	ready_next_a: assert property (setup_s |=> pready_out) else $error("no ready after setup");
	unmapped_err_a: assert property (pready_out && (paddr_in < 12'h1cc || paddr_in > 12'h1f4)
		|-> pslverr_out) else $error("unmapped access without error");
	upper_zero_a: assert property (rd |-> prdata_out[31:8] == 24'h0) else $error("upper bits set");
	reserved_zero_a: assert property (
		rd && paddr_in == 12'h1ec |-> prdata_out[7:6] == 2'b00) else $error("reserved bits set");
	reload_bit_zero_a: assert property (
		rd && paddr_in == 12'h1e0 |-> !prdata_out[2]) else $error("reload bit read as one");
	oe_source_a: assert property (
		$changed(pulse_output_n_oe_out) |-> $past(pw, 1) || $past(pw, 2) || $past(pw, 3))
		else $error("pin enable moved without write");
	ovf_clear_a: assert property (
		$fell(overflow_irq_out) |-> $past(tcs, 1) || $past(tcs, 2) || $past(tcs, 3))
		else $error("overflow request dropped without access");
	cap_clear_a: assert property (
		$fell(capture_irq_out[0]) |-> $past(c1, 1) || $past(c1, 2) || $past(c1, 3))
		else $error("capture request dropped without read");
	wake_halt_a: assert property (wake_out |-> $past(halted_in)) else $error("wake while running");
endmodule
bind art_timer art_timer_sva #(.NUM_PWM(NUM_PWM), .NUM_CAP(NUM_CAP)) i_sva (.ref_clk_in,
	.rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
	.pslverr_out, .halted_in, .pulse_output_n_oe_out, .overflow_irq_out, .capture_irq_out,
	.wake_out);

// ==== bench/art_far_model.sv ====
// Far side: capture sources and an external count clock
`timescale 1ns/1ps
module art_far_model (
	input  wire logic       clk_in,
	input  wire logic [1:0] cap_level_in,
	input  wire logic       ext_run_in,
	output logic      [1:0] capture_out,
	output logic            ext_clock_out
);
	logic [1:0] cap_d;
	logic [1:0] div;
	initial begin
		cap_d = 2'b00;
		div = 2'b00;
		capture_out = 2'b00;
		ext_clock_out = 1'b0;
	end
	// Sources lag two cycles; the event clock stands low when idle
	always @(posedge clk_in) begin
		cap_d <= cap_level_in;
		capture_out <= cap_d;
		div <= ext_run_in ? div + 2'b01 : 2'b00;
		ext_clock_out <= ext_run_in & div[1];
	end
endmodule

// ==== bench/tb_auto_reload_pwm_timer_regs.sv ====
// Self-checking bench for the auto-reload PWM timer
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
	$display("unexpected at %0t: got %h, expected %h", $time, a, e); end end
module tb_auto_reload_pwm_timer_regs;
	localparam logic [11:0] A_DUTY0 = 12'(art_pkg::IDX_DUTY0) * 4, A_PWM = 12'(art_pkg::IDX_PWM_OUTPUT_CONTROL) * 4;
	localparam logic [11:0] A_TCS = 12'(art_pkg::IDX_TCS) * 4, A_CAR = 12'(art_pkg::IDX_CAR) * 4;
	localparam logic [11:0] A_ARR = 12'(art_pkg::IDX_ARR) * 4, A_CCS = 12'(art_pkg::IDX_CCS) * 4;
	localparam logic [11:0] A_CAP1 = 12'(art_pkg::IDX_CAP1) * 4, A_CAP2 = 12'(art_pkg::IDX_CAP2) * 4;
	logic        clk, rst_n, psel, penable, pwrite, halted, ext_run, ext_clk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, ovf_irq, wake;
	logic [1:0]  cap_lvl, cap_pin, cap_irq;
	logic [3:0]  pwm, oe, ev, pol;
	logic [32:0] exp_q[$];
	logic [32:0] exp_v;
	logic [7:0]  duty[4];
	logic [7:0]  v;
	int          errors, total_checks, wakes, ext_edges;
	art_timer i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .halted_in(halted),
		.ext_clock_in(ext_clk), .capture_input_n_in(cap_pin), .pulse_output_n_out(pwm),
		.pulse_output_n_oe_out(oe), .overflow_irq_out(ovf_irq), .capture_irq_out(cap_irq),
		.wake_out(wake));
	art_far_model i_far (.clk_in(clk), .cap_level_in(cap_lvl), .ext_run_in(ext_run),
		.capture_out(cap_pin), .ext_clock_out(ext_clk));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			exp_v = exp_q.pop_front();
			`CHK({pslverr, prdata}, exp_v)
		end
		if (wake) wakes++;
	end
	always @(posedge ext_clk) ext_edges++;
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back({a < 12'h1cc || a > 12'h1f4, 24'h0, e});
		apb(1'b0, a, 8'h00);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic finish_test();
		if (errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, halted, ext_run, paddr, pwdata, cap_lvl} = '0;
		{errors, total_checks, wakes, ext_edges} = '0;
		void'($urandom(32'hdaa6));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 12'h1cc; a <= 12'h1f8; a += 4) rd(12'(a), 8'h00);
		for (int i = 0; i < 4; i++) begin
			duty[i] = 8'($urandom);
			wr(A_DUTY0 - 12'(4 * i), duty[i]);
			rd(A_DUTY0 - 12'(4 * i), duty[i]);
		end
		v = 8'($urandom);
		wr(A_CCS, v | 8'hc3);
		rd(A_CCS, v & 8'h3c);
		wr(A_TCS, v & 8'hf7 | 8'h05);
		rd(A_TCS, v & 8'hf2);
		wr(A_TCS, 8'h00);
		wr(A_ARR, 8'h5a);
		wr(A_CAR, 8'h21);
		idle(10);
		rd(A_CAR, 8'h21);
		wr(A_TCS, 8'h04);
		rd(A_CAR, 8'h5a);
		// Divide by eight for about sixty cycles gives seven counts
		wr(A_CAR, 8'h00);
		wr(A_TCS, 8'h38);
		idle(57);
		wr(A_TCS, 8'h00);
		rd(A_CAR, 8'h07);
		// Twenty-three counts from F0h wrap once before the stop
		wr(A_ARR, 8'hf0);
		wr(A_CAR, 8'hf0);
		wr(A_TCS, 8'h0a);
		idle(20);
		wr(A_TCS, 8'h02);
		`CHK(ovf_irq, 1'b1)
		rd(A_TCS, 8'h03);
		rd(A_TCS, 8'h02);
		wr(A_CAR, 8'h00);
		wr(A_TCS, 8'h88);
		ext_run <= 1'b1;
		idle(30);
		ext_run <= 1'b0;
		idle(10);
		wr(A_TCS, 8'h00);
		rd(A_CAR, 8'(ext_edges));
		// Full-range period so every compare shadow loads once
		wr(A_ARR, 8'h00);
		wr(A_TCS, 8'h08);
		idle(300);
		wr(A_TCS, 8'h00);
		for (int p = 0; p < 2; p++) begin
			pol = p ? 4'h5 : 4'h0;
			wr(A_PWM, p ? 8'h55 : 8'hf0);
			for (int c = 0; c < 256; c += 85) begin
				wr(A_CAR, 8'(c));
				idle(3);
				for (int i = 0; i < 4; i++) ev[i] = (8'(c) <= duty[i]) ^ pol[i];
				`CHK(pwm, ev)
				`CHK(oe, p ? 4'h5 : 4'hf)
			end
		end
		wr(A_CCS, 8'h3c);
		wr(A_CAR, 8'h37);
		cap_lvl <= 2'b01;
		idle(8);
		`CHK(cap_irq, 2'b01)
		wr(A_CAR, 8'h44);
		cap_lvl <= 2'b00;
		idle(6);
		cap_lvl <= 2'b01;
		idle(8);
		rd(A_CCS, 8'h3d);
		rd(A_CAP1, 8'h37);
		idle(3);
		`CHK(cap_irq, 2'b00)
		halted <= 1'b1;
		cap_lvl <= 2'b11;
		idle(8);
		`CHK(wakes, 1)
		`CHK(cap_irq, 2'b10)
		halted <= 1'b0;
		rd(A_CAP2, 8'h44);
		wr(A_CCS, 8'h0c);
		wr(A_CAR, 8'h66);
		cap_lvl <= 2'b00;
		idle(8);
		rd(A_CAP1, 8'h66);
		rd(A_CAP2, 8'h66);
		if (exp_q.size() != 0) errors++;
		finish_test();
	end
	initial begin
		#40000;
		errors++;
		finish_test();
	end
endmodule
